// ==== hdl/sbf_framer.sv ====
// response framer and command checksum checker for sideband control packets
//
// The register addresses and the APB interface to the registers were left to the implementer.
`include "sbf_consts.svh"

module sbf_framer import sbf_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic tx_start_i,
    input wire logic [7:0] tx_mc_id_i,
    input wire logic [7:0] tx_iid_i,
    input wire logic [7:0] tx_type_i,
    input wire logic [7:0] tx_chan_i,
    input wire logic [15:0] tx_resp_code_i,
    input wire logic [15:0] tx_reason_code_i,
    input wire logic [15:0] tx_poll_time_i,
    input wire logic [11:0] tx_data_len_i,
    output logic tx_busy_o,
    input wire logic pl_valid_i,
    input wire logic [7:0] pl_data_i,
    output logic pl_ready_o,
    output logic out_valid_o,
    output logic [7:0] out_data_o,
    output logic out_last_o,
    input wire logic out_ready_i,
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_data_i,
    input wire logic rx_last_i,
    output logic rx_accept_o,
    output logic rx_drop_o,
    output logic rx_poll_o,
    output logic [11:0] rx_plen_o
);

    // pick byte sel of a word, most significant byte first
    function automatic logic [7:0] be_byte(input logic [31:0] w, input logic [1:0] sel);
        be_byte = w[8 * (3 - int'(sel)) +: 8];
    endfunction

    // checksum offset: header plus payload rounded up to a word
    function automatic sbf_idx_t csum_off(input logic [11:0] len);
        logic [12:0] rnd;
        rnd = {1'b0, len} + 13'd3;
        csum_off = `SBF_HDR_BYTES + {rnd[12:2], 2'b00};
    endfunction

    // word contribution of one byte at a given index
    function automatic logic [31:0] word_part(input logic [7:0] b, input logic odd);
        word_part = odd ? {24'h0, b} : {16'h0, b, 8'h00};
    endfunction

    logic [1:0] ctrl_q;
    logic [15:0] rx_ok_cnt_q;
    logic [15:0] rx_bad_cnt_q;
    logic [15:0] tx_cnt_q;
    sbf_tx_e state_q;
    sbf_idx_t idx_q;
    logic [31:0] sum_q;
    logic [7:0] mc_q, iid_q, type_q, chan_q;
    logic [31:0] codes_q;
    logic [15:0] poll_q;
    logic [11:0] plen_q;
    logic defer_q;
    logic [7:0] byte_c;
    logic byte_v;
    logic buf_ready;
    logic emit;
    logic last_c;
    logic [31:0] csum_word;
    sbf_idx_t pl_end;
    logic out_v_q, out_l_q, skid_v_q, skid_l_q;
    logic [7:0] out_d_q, skid_d_q;
    logic pready_q, pslverr_q;
    logic [31:0] prdata_q;
    sbf_idx_t rx_idx_q;
    logic [11:0] rx_len_q;
    logic [31:0] rx_sum_q, rx_csum_q, rx_csum_d;
    logic rx_acc_q, rx_drop_q, rx_poll_q;
    logic rx_ok;

    // apb slave: one wait state, error on unmapped offsets
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            ctrl_q <= `SBF_CTRL_RST;
        end else begin
            pready_q <= psel_i && penable_i && !pready_q;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            if (psel_i && penable_i && !pready_q) begin
                unique case (paddr_i)
                    `SBF_REG_CTRL: begin
                        if (pwrite_i) begin
                            ctrl_q <= pwdata_i[1:0];
                        end else begin
                            prdata_q <= {30'h0, ctrl_q};
                        end
                    end
                    `SBF_REG_RXCNT: prdata_q <= pwrite_i ? 32'h0000_0000 : {rx_bad_cnt_q, rx_ok_cnt_q};
                    `SBF_REG_TXCNT: prdata_q <= pwrite_i ? 32'h0000_0000 : {16'h0, tx_cnt_q};
                    default: pslverr_q <= 1'b1;
                endcase
            end
        end
    end

    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;

    // compensation word, zero when generation is off
    assign csum_word = ctrl_q[`SBF_CTRL_GEN_BIT] ? (~sum_q + 32'h1) : 32'h0000_0000;
    assign pl_end = `SBF_HDR_BYTES + {1'b0, plen_q};

    // byte source of the transmit sequencer
    always_comb begin
        byte_c = 8'h00;
        byte_v = 1'b1;
        unique case (state_q)
            TX_IDLE: byte_v = 1'b0;
            TX_HDR: begin
                unique case (idx_q[3:0])
                    4'd0: byte_c = mc_q;
                    4'd1: byte_c = `SBF_HDR_REV;
                    4'd3: byte_c = iid_q;
                    4'd4: byte_c = type_q;
                    4'd5: byte_c = chan_q;
                    4'd6: byte_c = {4'h0, plen_q[11:8]};
                    4'd7: byte_c = plen_q[7:0];
                    default: byte_c = 8'h00;
                endcase
            end
            TX_CODES: byte_c = be_byte(codes_q, idx_q[1:0]);
            TX_POLL: byte_c = be_byte({16'h0, poll_q}, idx_q[1:0]);
            TX_DATA: begin
                byte_c = pl_data_i;
                byte_v = pl_valid_i;
            end
            TX_PAD: byte_c = 8'h00;
            TX_CSUM: byte_c = be_byte(csum_word, idx_q[1:0]);
            TX_EPAD: byte_c = 8'h00;
        endcase
    end

    assign emit = byte_v && buf_ready;
    assign pl_ready_o = (state_q == TX_DATA) && buf_ready;
    assign tx_busy_o = (state_q != TX_IDLE);
    assign last_c = ((state_q == TX_CSUM) && (idx_q[1:0] == 2'd3) && (idx_q >= `SBF_MIN_BODY_BYTES - 13'd1))
        || ((state_q == TX_EPAD) && (idx_q == `SBF_MIN_BODY_BYTES - 13'd1));

    // transmit sequencer
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q <= TX_IDLE;
            idx_q <= 13'd0;
        end else if (state_q == TX_IDLE) begin
            idx_q <= 13'd0;
            if (tx_start_i) begin
                state_q <= TX_HDR;
            end
        end else if (emit) begin
            idx_q <= idx_q + 13'd1;
            unique case (state_q)
                TX_HDR: if (idx_q == `SBF_HDR_BYTES - 13'd1) state_q <= TX_CODES;
                TX_CODES: begin
                    if (idx_q == `SBF_IDX_CODES_END) begin
                        if (defer_q) state_q <= TX_POLL;
                        else if (plen_q == `SBF_CODE_BYTES) state_q <= TX_CSUM;
                        else state_q <= TX_DATA;
                    end
                end
                TX_POLL: if (idx_q == `SBF_IDX_POLL_END) state_q <= TX_CSUM;
                TX_DATA: begin
                    if (idx_q == pl_end - 13'd1) begin
                        state_q <= (pl_end[1:0] != 2'd0) ? TX_PAD : TX_CSUM;
                    end
                end
                TX_PAD: if (idx_q[1:0] == 2'd3) state_q <= TX_CSUM;
                TX_CSUM: begin
                    if (idx_q[1:0] == 2'd3) begin
                        state_q <= last_c ? TX_IDLE : TX_EPAD;
                    end
                end
                TX_EPAD: if (last_c) state_q <= TX_IDLE;
                default: state_q <= TX_IDLE;
            endcase
        end
    end

    // response fields latched at start
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mc_q <= 8'h00;
            iid_q <= 8'h00;
            type_q <= 8'h00;
            chan_q <= 8'h00;
            codes_q <= 32'h0000_0000;
            poll_q <= 16'h0000;
            plen_q <= 12'h000;
            defer_q <= 1'b0;
        end else if (state_q == TX_IDLE && tx_start_i) begin
            mc_q <= tx_mc_id_i;
            iid_q <= tx_iid_i;
            type_q <= tx_type_i;
            chan_q <= tx_chan_i;
            codes_q <= {tx_resp_code_i, tx_reason_code_i};
            poll_q <= tx_poll_time_i;
            defer_q <= (tx_resp_code_i == `SBF_RESP_DEFERRED);
            plen_q <= (tx_resp_code_i == `SBF_RESP_DEFERRED) ? `SBF_DEFER_LEN
                : tx_data_len_i + `SBF_CODE_BYTES;
        end
    end

    // running word sum over header and payload
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sum_q <= 32'h0000_0000;
        end else if (state_q == TX_IDLE) begin
            sum_q <= 32'h0000_0000;
        end else if (emit && state_q inside {TX_HDR, TX_CODES, TX_POLL, TX_DATA}) begin
            sum_q <= sum_q + word_part(byte_c, idx_q[0]);
        end
    end

    // frames sent counter
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tx_cnt_q <= 16'h0000;
        end else if (emit && last_c) begin
            tx_cnt_q <= tx_cnt_q + 16'h1;
        end
    end

    // two-entry output buffer: output stage plus skid stage
    assign buf_ready = !skid_v_q;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            out_v_q <= 1'b0;
            out_d_q <= 8'h00;
            out_l_q <= 1'b0;
            skid_v_q <= 1'b0;
            skid_d_q <= 8'h00;
            skid_l_q <= 1'b0;
        end else if (!out_v_q || out_ready_i) begin
            if (skid_v_q) begin
                out_v_q <= 1'b1;
                out_d_q <= skid_d_q;
                out_l_q <= skid_l_q;
                skid_v_q <= 1'b0;
            end else begin
                out_v_q <= emit;
                out_d_q <= byte_c;
                out_l_q <= last_c;
            end
        end else if (emit) begin
            skid_v_q <= 1'b1;
            skid_d_q <= byte_c;
            skid_l_q <= last_c;
        end
    end

    assign out_valid_o = out_v_q;
    assign out_data_o = out_d_q;
    assign out_last_o = out_l_q;

    // receive: compensation bytes gathered at the rounded offset
    always_comb begin
        rx_csum_d = rx_csum_q;
        if (rx_valid_i && rx_idx_q >= csum_off(rx_len_q) && rx_idx_q < csum_off(rx_len_q) + 13'd4) begin
            rx_csum_d = {rx_csum_q[23:0], rx_data_i};
        end
    end

    // verdict: zero field or verification off accepts
    assign rx_ok = !ctrl_q[`SBF_CTRL_VERIFY_BIT] || (rx_csum_d == 32'h0000_0000)
        || (rx_sum_q + rx_csum_d == 32'h0000_0000);

    // receive checker
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rx_idx_q <= 13'd0;
            rx_len_q <= 12'h000;
            rx_sum_q <= 32'h0000_0000;
            rx_csum_q <= 32'h0000_0000;
            rx_acc_q <= 1'b0;
            rx_drop_q <= 1'b0;
            rx_poll_q <= 1'b0;
            rx_ok_cnt_q <= 16'h0000;
            rx_bad_cnt_q <= 16'h0000;
        end else begin
            rx_acc_q <= 1'b0;
            rx_drop_q <= 1'b0;
            if (rx_valid_i) begin
                rx_csum_q <= rx_csum_d;
                if (rx_idx_q == 13'd6) begin
                    rx_len_q[11:8] <= rx_data_i[3:0];
                    rx_poll_q <= rx_data_i[`SBF_FLAG_POLL_BIT];
                end
                if (rx_idx_q == 13'd7) rx_len_q[7:0] <= rx_data_i;
                if (rx_idx_q < csum_off(rx_len_q)) begin
                    rx_sum_q <= rx_sum_q + word_part(rx_data_i, rx_idx_q[0]);
                end
                if (rx_last_i) begin
                    rx_idx_q <= 13'd0;
                    rx_sum_q <= 32'h0000_0000;
                    rx_csum_q <= 32'h0000_0000;
                    rx_acc_q <= rx_ok;
                    rx_drop_q <= !rx_ok;
                    if (rx_ok) rx_ok_cnt_q <= rx_ok_cnt_q + 16'h1;
                    else rx_bad_cnt_q <= rx_bad_cnt_q + 16'h1;
                end else if (rx_idx_q != 13'h1FFF) begin
                    rx_idx_q <= rx_idx_q + 13'd1;
                end
            end
        end
    end

    assign rx_accept_o = rx_acc_q;
    assign rx_drop_o = rx_drop_q;
    assign rx_poll_o = rx_poll_q;
    assign rx_plen_o = rx_len_q;

    // checks on the transmit and receive paths
    sequence s_rx_end_zero;
        rx_valid_i && rx_last_i && (rx_csum_d == 32'h0000_0000);
    endsequence

    sequence s_codes_done;
        emit && (state_q == TX_CODES) && (idx_q == `SBF_IDX_CODES_END) && !defer_q && (plen_q != `SBF_CODE_BYTES);
    endsequence

    AST_LEN_LOW: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        emit && state_q == TX_HDR && idx_q == 13'd7 |-> byte_c == plen_q[7:0])
        else $error("length low byte wrong");
    AST_FLAGS_ZERO: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        emit && state_q == TX_HDR && (idx_q == 13'd2 || idx_q >= 13'd8 || idx_q == 13'd6)
        |-> byte_c[7:4] == 4'h0 && (idx_q == 13'd6 || byte_c == 8'h00))
        else $error("reserved header bits not zero");
    AST_ALIGN: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        state_q == TX_CSUM && $past(state_q) != TX_CSUM |-> idx_q[1:0] == 2'd0 && idx_q == csum_off(plen_q))
        else $error("checksum not word aligned");
    AST_MIN_FRAME: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        emit && last_c |-> idx_q >= `SBF_MIN_BODY_BYTES - 13'd1)
        else $error("frame body short");
    AST_NO_GEN_ZERO: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        emit && state_q == TX_CSUM && !ctrl_q[`SBF_CTRL_GEN_BIT] |-> byte_c == 8'h00)
        else $error("checksum not zero with generation off");
    AST_GEN_SUM: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        state_q == TX_CSUM && ctrl_q[`SBF_CTRL_GEN_BIT] |-> sum_q + csum_word == 32'h0000_0000)
        else $error("compensation does not cancel sum");
    AST_DATA_AFTER_CODES: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        s_codes_done |=> state_q == TX_DATA && idx_q == 13'd20)
        else $error("data not after code word");
    AST_DEFER_PAD: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        emit && state_q == TX_POLL && idx_q[1] == 1'b0 |-> byte_c == 8'h00 && plen_q == `SBF_DEFER_LEN)
        else $error("deferred payload malformed");
    AST_RX_ZERO_ACCEPT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        s_rx_end_zero |=> rx_accept_o && !rx_drop_o)
        else $error("zero checksum packet not accepted");
    AST_RX_DROP: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        rx_drop_o |-> $past(ctrl_q[`SBF_CTRL_VERIFY_BIT]) && !rx_accept_o)
        else $error("drop without verification");

endmodule // sbf_framer

// ==== hdl/sbf_consts.svh ====
// constants of the sideband control packet framer
`ifndef SBF_CONSTS_SVH
`define SBF_CONSTS_SVH

// packet geometry, counted in bytes
`define SBF_HDR_BYTES 13'd16
`define SBF_MIN_BODY_BYTES 13'd46
`define SBF_CODE_BYTES 12'd4
`define SBF_DEFER_LEN 12'd8
`define SBF_IDX_CODES_END 13'd19
`define SBF_IDX_POLL_END 13'd23

// header and response code field values
`define SBF_HDR_REV 8'h01
`define SBF_RESP_DEFERRED 16'h0004
`define SBF_FLAG_POLL_BIT 4

// register byte offsets
`define SBF_REG_CTRL 12'h000
`define SBF_REG_RXCNT 12'h004
`define SBF_REG_TXCNT 12'h008

// control register fields and reset value
`define SBF_CTRL_GEN_BIT 0
`define SBF_CTRL_VERIFY_BIT 1
`define SBF_CTRL_RST 2'h0

`endif

// ==== hdl/sbf_pkg.sv ====
// types of the sideband control packet framer
package sbf_pkg;

    // transmit sequencer states
    typedef enum logic [2:0] {
        TX_IDLE,
        TX_HDR,
        TX_CODES,
        TX_POLL,
        TX_DATA,
        TX_PAD,
        TX_CSUM,
        TX_EPAD
    } sbf_tx_e;

    typedef logic [12:0] sbf_idx_t;

endpackage

// ==== bench/sbf_mc_model.sv ====
// management controller model: response sink with stalls, command source
module sbf_mc_model (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic out_valid_i,
    input wire logic [7:0] out_data_i,
    input wire logic out_last_i,
    output logic out_ready_o,
    output logic rx_valid_o,
    output logic [7:0] rx_data_o,
    output logic rx_last_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] got[$];
    int last_idx = -1;
    int n_frames = 0;
    logic [1:0] stall_q;
    // sink stalls one cycle in three
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            stall_q <= 2'h0;
        end else begin
            stall_q <= (stall_q == 2'h2) ? 2'h0 : stall_q + 2'h1;
        end
    end
    assign out_ready_o = (stall_q != 2'h2);
    // collect response bytes and frame ends
    always @(posedge clk_i) begin
        if (out_valid_i && out_ready_o) begin
            if (out_last_i) begin
                last_idx = got.size();
                n_frames++;
            end
            got.push_back(out_data_i);
        end
    end
    // command lines idle low at start
    initial begin
        rx_valid_o = 1'b0;
        rx_data_o = 8'h00;
        rx_last_o = 1'b0;
    end
    // one command byte per cycle; released line shows the inverted last byte
    task automatic send(input logic [7:0] b[$]);
        for (int i = 0; i < b.size(); i++) begin
            @(posedge clk_i);
            rx_valid_o <= 1'b1;
            rx_data_o <= b[i];
            rx_last_o <= (i == b.size() - 1);
        end
        @(posedge clk_i);
        rx_valid_o <= 1'b0;
        rx_data_o <= ~b[b.size() - 1];
        rx_last_o <= 1'b0;
    endtask
endmodule // sbf_mc_model

// ==== bench/tb_sbf_framer.sv ====
// self-checking testbench of the sideband control packet framer
module tb_sbf_framer;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000, dlen = 12'h000;
    logic [31:0] hdr = 32'h0000_0000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, tx_start = 1'b0, tx_busy, pl_valid = 1'b0, pl_ready;
    logic [15:0] rc = 16'h0, rs = 16'h0, pt = 16'h0;
    logic [7:0] pl_data = 8'h00, out_data, rx_data;
    logic out_valid, out_last, out_ready, rx_valid, rx_last, rx_accept, rx_drop, rx_poll;
    logic [11:0] rx_plen;
    logic [7:0] exp[$], body[$], pq[$];
    int n_errors = 0, n_compared = 0, pidx = 0;
    always #20 clk = ~clk;

    sbf_framer uut (
        .clk_i(clk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .tx_start_i(tx_start), .tx_mc_id_i(hdr[31:24]), .tx_iid_i(hdr[23:16]),
        .tx_type_i(hdr[15:8]), .tx_chan_i(hdr[7:0]),
        .tx_resp_code_i(rc), .tx_reason_code_i(rs), .tx_poll_time_i(pt), .tx_data_len_i(dlen),
        .tx_busy_o(tx_busy), .pl_valid_i(pl_valid), .pl_data_i(pl_data), .pl_ready_o(pl_ready),
        .out_valid_o(out_valid), .out_data_o(out_data), .out_last_o(out_last), .out_ready_i(out_ready),
        .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_last_i(rx_last), .rx_accept_o(rx_accept),
        .rx_drop_o(rx_drop), .rx_poll_o(rx_poll), .rx_plen_o(rx_plen));
    sbf_mc_model mc (.clk_i(clk), .rst_b_i(rst_b), .out_valid_i(out_valid), .out_data_i(out_data),
        .out_last_i(out_last), .out_ready_o(out_ready), .rx_valid_o(rx_valid), .rx_data_o(rx_data),
        .rx_last_o(rx_last));

    // payload source advances on each taken byte
    always @(posedge clk) begin
        if (pl_valid && pl_ready) begin
            pidx <= pidx + 1;
            pl_data <= (pidx + 1 < pq.size()) ? pq[pidx + 1] : ~pl_data;
        end
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] want, input string what);
        n_compared++;
        if (got !== want) begin
            n_errors++;
            $display("[ERR] %0t %s got %h want %h", $time, what, got, want);
        end
    endtask

    // one APB transfer, waits for pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // expected packet: header, body, word pad, checksum (0 none, 1 good, 2 bad), frame pad
    function automatic void pack(input logic [31:0] h, input logic [7:0] b6, input logic [7:0] b7, input int cm);
        logic [31:0] s;
        exp = {h[31:24], 8'h01, 8'h00, h[23:16], h[15:8], h[7:0], b6, b7};
        repeat (8) exp.push_back(8'h00);
        exp = {exp, body};
        while (exp.size() % 4 != 0) exp.push_back(8'h00);
        s = 32'h0;
        for (int i = 0; i < exp.size(); i += 2) s += {exp[i], exp[i + 1]};
        s = (cm == 0) ? 32'h0 : (32'h0 - s + ((cm == 2) ? 32'h1 : 32'h0));
        exp = {exp, s[31:24], s[23:16], s[15:8], s[7:0]};
        while (exp.size() < 46) exp.push_back(8'h00);
    endfunction

    // send one response and compare it byte by byte
    task automatic tx_frame(input logic gen, input logic [15:0] c, input logic [15:0] r, input logic [15:0] p,
        input logic [31:0] h);
        int n;
        logic [11:0] len;
        len = (c == 16'h0004) ? 12'd8 : 12'(pq.size()) + 12'd4;
        body = {c[15:8], c[7:0], r[15:8], r[7:0]};
        if (c == 16'h0004) body = {body, 8'h00, 8'h00, p[15:8], p[7:0]};
        else body = {body, pq};
        pack(h, {4'h0, len[11:8]}, len[7:0], gen ? 1 : 0);
        apb(1'b1, 12'h000, {31'h0, gen});
        mc.got.delete();
        n = mc.n_frames;
        @(posedge clk);
        hdr <= h;
        dlen <= 12'(pq.size());
        rc <= c;
        rs <= r;
        pt <= p;
        tx_start <= 1'b1;
        pidx <= 0;
        pl_data <= (pq.size() > 0) ? pq[0] : 8'h00;
        pl_valid <= (c != 16'h0004);
        @(posedge clk);
        tx_start <= 1'b0;
        #1;
        cmp(tx_busy, 1'b1, "busy after start");
        @(posedge clk);
        tx_start <= 1'b1;
        @(posedge clk);
        tx_start <= 1'b0;
        repeat (300) if (mc.n_frames == n) @(posedge clk);
        pl_valid <= 1'b0;
        cmp(mc.got.size(), exp.size(), "frame length");
        foreach (exp[i]) cmp(mc.got[i], exp[i], "frame byte");
        cmp(mc.last_idx, exp.size() - 1, "last marker");
    endtask

    // one command in, verdict, poll flag and length out
    task automatic rx_pkt(input logic v, input int cm, input logic pol, input logic ok);
        pack(hdr, {3'b101, pol, 4'h0}, 8'd5, cm);
        apb(1'b1, 12'h000, {30'h0, v, 1'b0});
        mc.send(exp);
        #1;
        cmp({rx_accept, rx_drop}, {ok, !ok}, "verdict");
        if (ok) cmp({rx_poll, rx_plen}, {pol, 12'd5}, "poll and length");
    endtask

    task automatic complete_run;
        $display("compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // watchdog against a hang
    initial begin
        #200000;
        n_errors++;
        complete_run;
    end

    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        pq = {8'hAA, 8'hBB, 8'hC3};
        for (int a = 0; a < 12; a += 4) begin
            apb(1'b0, a[11:0], 32'h0);
            cmp({31'h0, err}, 32'h0, "reset error");
            cmp(rd, 32'h0, "reset value");
        end
        apb(1'b0, 12'h00C, 32'h0);
        cmp(err, 1'b1, "unmapped error");
        apb(1'b1, 12'h008, 32'hFFFF);
        apb(1'b0, 12'h008, 32'h0);
        cmp(rd, 32'h0, "read only");
        tx_frame(1'b0, 16'h0001, 16'h0002, 16'h0000, 32'h5A21_8503);
        tx_frame(1'b1, 16'h0001, 16'h0002, 16'h0000, 32'hC31E_8A00);
        tx_frame(1'b1, 16'h0004, 16'h0000, 16'h1234, 32'h0F7B_C4FF);
        pq.delete();
        tx_frame(1'b1, 16'h0000, 16'h0000, 16'h0000, 32'h0102_8304);
        for (int i = 0; i < 30; i++) pq.push_back(8'(8'h40 + i));
        tx_frame(1'b1, 16'h0003, 16'h0009, 16'h0000, 32'hA5E6_9C07);
        apb(1'b0, 12'h008, 32'h0);
        cmp(rd[15:0], 16'd5, "frames sent");
        body = {8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
        rx_pkt(1'b1, 1, 1'b1, 1'b1);
        rx_pkt(1'b1, 2, 1'b0, 1'b0);
        rx_pkt(1'b1, 0, 1'b0, 1'b1);
        rx_pkt(1'b0, 2, 1'b1, 1'b1);
        apb(1'b0, 12'h004, 32'h0);
        cmp(rd, {16'd1, 16'd3}, "receive counts");
        complete_run;
    end
endmodule // tb_sbf_framer
